// *** design/pio_defs.svh ***
// Purpose: Register offsets, field positions, reset values and counts for the port I/O block
// Assumes: 8-bit special function register space
// Notes: Definitions only
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// Register offsets
`define PIO_ADDR_ROUTE0 8'he1
`define PIO_ADDR_ROUTE2 8'he3
`define PIO_ADDR_DRIVE 8'hf6
`define PIO_ADDR_MASK0 8'hfe
`define PIO_ADDR_MAT0 8'hfd
`define PIO_ADDR_MASK1 8'hee
`define PIO_ADDR_MAT1 8'hed
`define PIO_ADDR_LATCH0 8'ha0
`define PIO_ADDR_MDIN0 8'ha4
`define PIO_ADDR_MDOUT0 8'ha8
`define PIO_ADDR_SKIP0 8'hac

// Field positions
`define PIO_BIT_SYSCLK 7
`define PIO_BIT_CMP1A 6
`define PIO_BIT_CMP1 5
`define PIO_BIT_CMP0A 4
`define PIO_BIT_CMP0 3
`define PIO_BIT_SMBUS 2
`define PIO_BIT_SPI 1
`define PIO_BIT_UART 0
`define PIO_BIT_PUD 7
`define PIO_BIT_XBE 6
`define PIO_UART_TX_PIN 4
`define PIO_UART_RX_PIN 5

// Reset values
`define PIO_RST_ROUTE0 8'h00
`define PIO_RST_DRIVE 3'h7
`define PIO_RST_MASK 8'h00
`define PIO_RST_MAT 8'hff
`define PIO_RST_LATCH 8'hff
`define PIO_RST_MDIN 8'hff
`define PIO_RST_MDOUT 8'h00
`define PIO_RST_SKIP 8'h00

// Counts
`define PIO_SYNC_STAGES 2
`define PIO_PORTS 3
`define PIO_XBAR_PINS 16

`endif

// *** design/pio_pkg.sv ***
// Purpose: Shared types for the port I/O block
// Assumes: Nothing beyond the defs header
// Notes: Register kinds are decoded once by a function in the main module
package pio_pkg;

    typedef logic [7:0] pio_byte_t;

    typedef enum logic [3:0] {
        PIO_R_NONE = 4'b0000,
        PIO_R_LATCH = 4'b0001,
        PIO_R_MDIN = 4'b0010,
        PIO_R_MDOUT = 4'b0011,
        PIO_R_SKIP = 4'b0100,
        PIO_R_MASK = 4'b0101,
        PIO_R_MAT = 4'b0110,
        PIO_R_ROUTE0 = 4'b0111,
        PIO_R_ROUTE2 = 4'b1000,
        PIO_R_DRIVE = 4'b1001
    } pio_reg_t;

endpackage

// *** design/pio_sync.sv ***
// Purpose: Two-flop synchroniser for pad input levels
// Assumes: Pads idle high through their pull-ups
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module pio_sync #(
    parameter int WIDTH = 18
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Reset to high so an idle pulled-up pad does not look like a change
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

// *** design/pio_pad_drv.sv ***
// Purpose: Registered pad control for every pin
// Assumes: Next values are computed by the caller each cycle
// Notes: Reset leaves every pad undriven with pull-up on and high drive
`timescale 1ns/100ps
module pio_pad_drv #(
    parameter int WIDTH = 18
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] oe_d_i,
    input wire logic [WIDTH-1:0] out_d_i,
    input wire logic [WIDTH-1:0] pu_d_i,
    input wire logic [WIDTH-1:0] rx_d_i,
    input wire logic [WIDTH-1:0] hi_d_i,
    output logic [WIDTH-1:0] oe_o,
    output logic [WIDTH-1:0] out_o,
    output logic [WIDTH-1:0] pu_o,
    output logic [WIDTH-1:0] rx_o,
    output logic [WIDTH-1:0] hi_o
);

    // Registering keeps the pad controls glitch free
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            oe_o <= '0;
            out_o <= '0;
            pu_o <= '1;
            rx_o <= '1;
            hi_o <= '1;
        end else if (ce_i) begin
            oe_o <= oe_d_i;
            out_o <= out_d_i;
            pu_o <= pu_d_i;
            rx_o <= rx_d_i;
            hi_o <= hi_d_i;
        end
    end

endmodule

// *** design/pio_xbar_ctrl.sv ***
// Purpose: Port I/O cell control, port match and first crossbar routing register
// Assumes: Special function register strobes are synchronous to clk_sys_i; pads are asynchronous and synchronised here
// Notes: Priority pin assignment is done outside; this block gates and applies it
//
// Functional notes
// - Mode bit 1 makes pin digital
// - Push-pull drives pad to latch or peripheral value
// - Open-drain drives only low, never high
// - Pull-up on when idle, off driving
// - Global disable kills all pull-ups
// - Digital pin read returns pad level
// - Open-drain with latch one is input
// - Open-drain low from peripheral or latch
// - Skipped pin never gets crossbar function
// - One drive strength bit per port
// - Reset selects high drive everywhere
// - Masked pins differing raise mismatch
// - Mismatch ignores crossbar routing
// - Mismatch offered as interrupt and wake
// - Port write stores output latch
// - Ordinary port read returns pins
// - Read-modify-write reads the latch
// - Route bit 7 sends system clock
// - Route bits 6-3 send comparator outputs
// - Route bits 2,1 enable SMBus, SPI
// - Route bit 0 puts UART on P0.4/P0.5
// - No crossbar pin driven before enable
// - Reset leaves pads undriven, pulled up
`timescale 1ns/100ps
`include "pio_defs.svh"
module pio_xbar_ctrl #(
    parameter int P2_PINS = 2,
    parameter int NPIN = 16 + P2_PINS
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire pio_pkg::pio_byte_t sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic sfr_rmw_i,
    output pio_pkg::pio_byte_t sfr_rdata_o,
    input wire logic [NPIN-1:0] pad_in_i,
    output logic [NPIN-1:0] pad_out_o,
    output logic [NPIN-1:0] pad_oe_o,
    output logic [NPIN-1:0] pad_pullup_o,
    output logic [NPIN-1:0] pad_rx_en_o,
    output logic [NPIN-1:0] pad_hidrive_o,
    input wire logic [NPIN-1:0] periph_own_i,
    input wire logic [NPIN-1:0] periph_val_i,
    input wire logic uart_tx_i,
    output logic uart_rx_o,
    output logic [7:0] route_en_o,
    output logic [NPIN-1:0] skip_o,
    input wire logic idle_i,
    output logic mismatch_o,
    output logic mismatch_wake_o
);
    import pio_pkg::*;

    // Register kind for an address; shared by write and read paths
    function automatic pio_reg_t reg_kind(input logic [7:0] a);
        pio_reg_t k;
        k = PIO_R_NONE;
        if (a == `PIO_ADDR_ROUTE0) k = PIO_R_ROUTE0;
        else if (a == `PIO_ADDR_ROUTE2) k = PIO_R_ROUTE2;
        else if (a == `PIO_ADDR_DRIVE) k = PIO_R_DRIVE;
        else if (a == `PIO_ADDR_MASK0 || a == `PIO_ADDR_MASK1) k = PIO_R_MASK;
        else if (a == `PIO_ADDR_MAT0 || a == `PIO_ADDR_MAT1) k = PIO_R_MAT;
        else if (a[7:2] == 6'h28 && a[1:0] != 2'h3) k = PIO_R_LATCH;
        else if (a[7:2] == 6'h29 && a[1:0] != 2'h3) k = PIO_R_MDIN;
        else if (a[7:2] == 6'h2a && a[1:0] != 2'h3) k = PIO_R_MDOUT;
        else if (a[7:2] == 6'h2b && a[1:0] != 2'h3) k = PIO_R_SKIP;
        return k;
    endfunction

    // Port index for an address; match registers exist for ports 0 and 1 only
    function automatic logic [1:0] reg_port(input logic [7:0] a);
        logic [1:0] p;
        p = a[1:0];
        if (a == `PIO_ADDR_MASK1 || a == `PIO_ADDR_MAT1) p = 2'h1;
        else if (a == `PIO_ADDR_MASK0 || a == `PIO_ADDR_MAT0) p = 2'h0;
        return p;
    endfunction

    // Implemented pins of a port; the short last port reads zero above its pins
    function automatic pio_byte_t port_bits(input logic [1:0] p);
        pio_byte_t m;
        m = 8'hff;
        if (p == 2'h2) m = 8'((16'h1 << P2_PINS) - 16'h1);
        return m;
    endfunction

    pio_byte_t latch_q [`PIO_PORTS];
    pio_byte_t mdin_q [`PIO_PORTS];
    pio_byte_t mdout_q [`PIO_PORTS];
    pio_byte_t skip_q [`PIO_PORTS];
    pio_byte_t mask_q [2];
    pio_byte_t mat_q [2];
    pio_byte_t route0_q;
    logic pud_q;
    logic xbe_q;
    logic [2:0] drive_q;
    pio_byte_t rdata_q;
    logic mismatch_q;
    logic wake_q;
    logic uart_rx_q;
    pio_byte_t route_out_q;
    logic [NPIN-1:0] skip_out_q;

    pio_reg_t wr_kind;
    logic [1:0] wr_port;
    logic wr_en;
    pio_reg_t rd_kind;
    logic [1:0] rd_port;

    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] latch_v;
    logic [NPIN-1:0] mdin_v;
    logic [NPIN-1:0] mdout_v;
    logic [NPIN-1:0] skip_v;
    logic [NPIN-1:0] oe_d;
    logic [NPIN-1:0] out_d;
    logic [NPIN-1:0] pu_d;
    logic [NPIN-1:0] hi_d;
    pio_byte_t rd_pins [`PIO_PORTS];
    pio_byte_t rdata_d;
    logic mismatch_d;

    // Pad levels are asynchronous to the core, so sample them twice first
    pio_sync #(
        .WIDTH(NPIN)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .d_i(pad_in_i),
        .q_o(pin_sync)
    );

    assign wr_kind = reg_kind(sfr_addr_i);
    assign wr_port = reg_port(sfr_addr_i);
    assign wr_en = sfr_wr_i && ce_i;
    assign rd_kind = wr_kind;
    assign rd_port = wr_port;

    // Per-port configuration and output latches
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < `PIO_PORTS; p++) begin
                latch_q[p] <= `PIO_RST_LATCH & port_bits(2'(p));
                mdin_q[p] <= `PIO_RST_MDIN & port_bits(2'(p));
                mdout_q[p] <= `PIO_RST_MDOUT;
                skip_q[p] <= `PIO_RST_SKIP;
            end
        end else if (wr_en) begin
            case (wr_kind)
                PIO_R_LATCH: latch_q[wr_port] <= sfr_wdata_i & port_bits(wr_port);
                PIO_R_MDIN: mdin_q[wr_port] <= sfr_wdata_i & port_bits(wr_port);
                PIO_R_MDOUT: mdout_q[wr_port] <= sfr_wdata_i & port_bits(wr_port);
                PIO_R_SKIP: skip_q[wr_port] <= sfr_wdata_i & port_bits(wr_port);
                default: ;
            endcase
        end
    end

    // Port match pattern and compare mask
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < 2; p++) begin
                mask_q[p] <= `PIO_RST_MASK;
                mat_q[p] <= `PIO_RST_MAT;
            end
        end else if (wr_en) begin
            if (wr_kind == PIO_R_MASK) mask_q[wr_port[0]] <= sfr_wdata_i;
            if (wr_kind == PIO_R_MAT) mat_q[wr_port[0]] <= sfr_wdata_i;
        end
    end

    // Routing, global pull-up disable, crossbar enable and drive strength
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            route0_q <= `PIO_RST_ROUTE0;
            pud_q <= 1'b0;
            xbe_q <= 1'b0;
            drive_q <= `PIO_RST_DRIVE;
        end else if (wr_en) begin
            if (wr_kind == PIO_R_ROUTE0) route0_q <= sfr_wdata_i;
            if (wr_kind == PIO_R_ROUTE2) begin
                pud_q <= sfr_wdata_i[`PIO_BIT_PUD];
                xbe_q <= sfr_wdata_i[`PIO_BIT_XBE];
            end
            if (wr_kind == PIO_R_DRIVE) drive_q <= sfr_wdata_i[2:0];
        end
    end

    // Flatten the per-port bytes into pin vectors
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            latch_v[i] = latch_q[i / 8][i % 8];
            mdin_v[i] = mdin_q[i / 8][i % 8];
            mdout_v[i] = mdout_q[i / 8][i % 8];
            skip_v[i] = skip_q[i / 8][i % 8];
        end
    end

    // Pin cell control: mode, output type, crossbar ownership and pull-up
    always_comb begin
        logic own;
        logic val;
        own = 1'b0;
        val = 1'b0;
        for (int i = 0; i < NPIN; i++) begin
            // Skipped pins and pins past the crossbar range stay general purpose
            own = xbe_q && !skip_v[i] && (i < `PIO_XBAR_PINS) && periph_own_i[i];
            val = periph_val_i[i];
            if (i == `PIO_UART_TX_PIN && route0_q[`PIO_BIT_UART]) begin
                own = xbe_q && !skip_v[i];
                val = uart_tx_i;
            end
            if (!own) val = latch_v[i];
            oe_d[i] = 1'b0;
            out_d[i] = 1'b0;
            if (!mdin_v[i]) begin
                // Analog pin: digital driver stays off
                oe_d[i] = 1'b0;
            end else if (i < `PIO_XBAR_PINS && !xbe_q) begin
                oe_d[i] = 1'b0;
            end else if (mdout_v[i]) begin
                oe_d[i] = 1'b1;
                out_d[i] = val;
            end else begin
                // Open drain: high side never on, latch one leaves pin as input
                oe_d[i] = !val;
                out_d[i] = 1'b0;
            end
            // Pull-up only while the cell is not driving
            pu_d[i] = mdin_v[i] && !pud_q && !oe_d[i];
            hi_d[i] = drive_q[i / 8];
        end
    end

    // Registered pad controls
    pio_pad_drv #(
        .WIDTH(NPIN)
    ) u_pad (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .oe_d_i(oe_d),
        .out_d_i(out_d),
        .pu_d_i(pu_d),
        .rx_d_i(mdin_v),
        .hi_d_i(hi_d),
        .oe_o(pad_oe_o),
        .out_o(pad_out_o),
        .pu_o(pad_pullup_o),
        .rx_o(pad_rx_en_o),
        .hi_o(pad_hidrive_o)
    );

    // Pad level per port; analog pins have no receiver and read zero
    always_comb begin
        for (int p = 0; p < `PIO_PORTS; p++) begin
            rd_pins[p] = 8'h00;
        end
        for (int i = 0; i < NPIN; i++) begin
            rd_pins[i / 8][i % 8] = pin_sync[i] && mdin_v[i];
        end
    end

    // Register read data; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        case (rd_kind)
            PIO_R_LATCH: begin
                if (sfr_rmw_i) rdata_d = latch_q[rd_port];
                else rdata_d = rd_pins[rd_port];
            end
            PIO_R_MDIN: rdata_d = mdin_q[rd_port];
            PIO_R_MDOUT: rdata_d = mdout_q[rd_port];
            PIO_R_SKIP: rdata_d = skip_q[rd_port];
            PIO_R_MASK: rdata_d = mask_q[rd_port[0]];
            PIO_R_MAT: rdata_d = mat_q[rd_port[0]];
            PIO_R_ROUTE0: rdata_d = route0_q;
            PIO_R_ROUTE2: rdata_d = {pud_q, xbe_q, 6'h00};
            PIO_R_DRIVE: rdata_d = {5'h00, drive_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i && sfr_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    // Compare masked pad levels to the expected pattern on both match ports
    always_comb begin
        mismatch_d = 1'b0;
        for (int p = 0; p < 2; p++) begin
            // Crossbar ownership plays no part, peripheral pins are watched too
            if ((rd_pins[p] & mask_q[p]) != (mat_q[p] & mask_q[p])) begin
                mismatch_d = 1'b1;
            end
        end
    end

    // Mismatch is a level: it stays while the pattern differs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mismatch_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce_i) begin
            mismatch_q <= mismatch_d;
            wake_q <= mismatch_d && idle_i;
        end
    end

    // Routing enables to the peripherals and the external priority decoder
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            route_out_q <= 8'h00;
            skip_out_q <= '0;
            uart_rx_q <= 1'b1;
        end else if (ce_i) begin
            // Nothing is routed until the crossbar itself is on
            route_out_q <= route0_q & {8{xbe_q}};
            skip_out_q <= skip_v;
            if (route0_q[`PIO_BIT_UART] && xbe_q && !skip_v[`PIO_UART_RX_PIN]) begin
                uart_rx_q <= pin_sync[`PIO_UART_RX_PIN];
            end else begin
                uart_rx_q <= 1'b1;
            end
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign mismatch_o = mismatch_q;
    assign mismatch_wake_o = wake_q;
    assign route_en_o = route_out_q;
    assign skip_o = skip_out_q;
    assign uart_rx_o = uart_rx_q;

endmodule

// *** bench/pio_xbar_ctrl_monitor.sv ***
// Purpose: Port-level checks on the port I/O block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into every instance of the block
`timescale 1ns/100ps
`include "pio_defs.svh"
module pio_xbar_ctrl_monitor #(
    parameter int NPIN = 18
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire pio_pkg::pio_byte_t sfr_rdata_o,
    input wire logic [NPIN-1:0] pad_oe_o,
    input wire logic [NPIN-1:0] pad_pullup_o,
    input wire logic [NPIN-1:0] pad_rx_en_o,
    input wire logic [NPIN-1:0] pad_hidrive_o,
    input wire logic [NPIN-1:0] skip_o,
    input wire logic [7:0] route_en_o,
    input wire logic uart_rx_o,
    input wire logic idle_i,
    input wire logic mismatch_o,
    input wire logic mismatch_wake_o
);
    import pio_pkg::*;
    logic route_wr;
    // Writes that may move the routing outputs
    assign route_wr = sfr_wr_i && ce_i &&
        (sfr_addr_i == `PIO_ADDR_ROUTE0 || sfr_addr_i == `PIO_ADDR_ROUTE2);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    reset_pads_a: assert property ($rose(rst_n_i) |->
        pad_oe_o == '0 && &pad_pullup_o && &pad_hidrive_o && route_en_o == 8'h00)
        else $error("pads not at reset state");
    drive_uniform_a: assert property (
        pad_hidrive_o[7:0] inside {8'h00, 8'hff} && pad_hidrive_o[15:8] inside {8'h00, 8'hff}
        && (&pad_hidrive_o[NPIN-1:16] || !(|pad_hidrive_o[NPIN-1:16])))
        else $error("drive strength not per port");
    pullup_idle_a: assert property ((pad_pullup_o & pad_oe_o) == '0)
        else $error("pull-up on while driving");
    analog_quiet_a: assert property ((~pad_rx_en_o & (pad_pullup_o | pad_oe_o)) == '0)
        else $error("analog pin driven or pulled");
    wake_idle_a: assert property ($past(ce_i) |->
        mismatch_wake_o == (mismatch_o && $past(idle_i)))
        else $error("wake differs from mismatch and idle");
    rx_unrouted_a: assert property (!route_en_o[0] |-> uart_rx_o)
        else $error("receive not idle while unrouted");
    rx_skipped_a: assert property (skip_o[5] |-> uart_rx_o)
        else $error("skipped pin reaches receive");
    rdata_hold_a: assert property ($past(rst_n_i) && !$past(sfr_rd_i && ce_i) |->
        $stable(sfr_rdata_o)) else $error("read data moved without read");
    route_write_a: assert property ($past(rst_n_i) && $changed(route_en_o) |->
        $past(route_wr) || $past(route_wr, 2)) else $error("routing moved without write");
endmodule

bind pio_xbar_ctrl pio_xbar_ctrl_monitor #(.NPIN(NPIN)) pio_xbar_ctrl_monitor_inst (
    .clk_sys_i, .rst_n_i, .ce_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
    .pad_oe_o, .pad_pullup_o, .pad_rx_en_o, .pad_hidrive_o, .skip_o, .route_en_o,
    .uart_rx_o, .idle_i, .mismatch_o, .mismatch_wake_o
);

// *** bench/pio_board.sv ***
// Purpose: Board nets on the port pins
// Assumes: Device drive wins over the board
// Notes: An undriven net with no pull-up toggles every cycle
`timescale 1ns/100ps
module pio_board #(
    parameter int NPIN = 18
) (
    input wire logic clk_sys_i,
    input wire logic [NPIN-1:0] pad_out_i,
    input wire logic [NPIN-1:0] pad_oe_i,
    input wire logic [NPIN-1:0] pad_pullup_i,
    input wire logic [NPIN-1:0] ext_en_i,
    input wire logic [NPIN-1:0] ext_val_i,
    output logic [NPIN-1:0] pad_o
);
    logic [NPIN-1:0] float_q = '0;
    // Floating nets show the inverse of their last level, never a held value
    always_ff @(posedge clk_sys_i) begin
        float_q <= ~pad_o;
    end
    // Pad level from device, board driver and pull-up
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                pad_pullup_i[i] ? 1'b1 : float_q[i];
        end
    end
endmodule

// *** bench/test_pio_xbar_ctrl.sv ***
// Purpose: Self-checking bench for the port I/O block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Board nets come from pio_board
`timescale 1ns/100ps
module test_pio_xbar_ctrl;
    import pio_pkg::*;
    localparam int NPIN = 18;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
    logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_rmw_i = 1'b0;
    logic uart_tx_i = 1'b1, idle_i = 1'b0, uart_rx_o, mismatch_o, mismatch_wake_o;
    logic [7:0] sfr_addr_i = 8'h00, route_en_o;
    pio_byte_t sfr_wdata_i = 8'h00, sfr_rdata_o;
    logic [NPIN-1:0] pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, pad_rx_en_o;
    logic [NPIN-1:0] pad_hidrive_o, skip_o, periph_own_i = '0, periph_val_i = '0;
    logic [NPIN-1:0] ext_en = '0, ext_val = '0;
    int num_errors = 0, compares = 0;

    pio_xbar_ctrl pio_xbar_ctrl_inst (.clk_sys_i, .rst_n_i, .ce_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_rd_i, .sfr_rmw_i, .sfr_rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o,
        .pad_pullup_o, .pad_rx_en_o, .pad_hidrive_o, .periph_own_i, .periph_val_i,
        .uart_tx_i, .uart_rx_o, .route_en_o, .skip_o, .idle_i, .mismatch_o,
        .mismatch_wake_o);
    pio_board pio_board_inst (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o),
        .pad_oe_i(pad_oe_o), .pad_pullup_i(pad_pullup_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_o(pad_in_i));

    // 20 MHz system clock
    always begin
        #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // One register write; strobe drops one cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        step(1);
        sfr_wr_i = 1'b0;
    endtask
    // Read, optionally as read-modify-write, and compare
    task automatic rdchk(input string what, input logic [7:0] a, input logic m,
        input logic [7:0] exp);
        step(1);
        sfr_addr_i = a;
        sfr_rmw_i = m;
        sfr_rd_i = 1'b1;
        step(1);
        sfr_rd_i = 1'b0;
        sfr_rmw_i = 1'b0;
        check(what, sfr_rdata_o, exp);
    endtask

    task automatic t_reset();
        check("oe", pad_oe_o, 0);
        check("pullup", pad_pullup_o, 18'h3ffff);
        check("rx_en", pad_rx_en_o, 18'h3ffff);
        check("hidrive", pad_hidrive_o, 18'h3ffff);
        rdchk("route0", 8'he1, 1'b0, 8'h00);
        rdchk("drive", 8'hf6, 1'b0, 8'h07);
        rdchk("unmapped", 8'h10, 1'b0, 8'h00);
        rdchk("p0 pins", 8'ha0, 1'b0, 8'hff);
        $display("t_reset done");
    endtask
    task automatic t_route();
        wr(8'he1, 8'hff);
        rdchk("route rb", 8'he1, 1'b0, 8'hff);
        step(1);
        check("route off", route_en_o, 0);
        wr(8'he3, 8'h40);
        for (int b = 0; b < 8; b++) begin
            wr(8'he1, 8'h01 << b);
            step(1);
            check("route bit", route_en_o, 32'h1 << b);
        end
        wr(8'he1, 8'h00);
        $display("t_route done");
    endtask
    task automatic t_cells();
        wr(8'haa, 8'h03);
        wr(8'ha2, 8'h02);
        step(1);
        check("pp oe/out", {pad_oe_o[17:16], pad_out_o[17:16]}, 4'b1110);
        check("pp pu", pad_pullup_o[17:16], 2'b00);
        wr(8'haa, 8'h00);
        step(3);
        check("od oe/out", {pad_oe_o[17:16], pad_out_o[17:16]}, 4'b0100);
        check("od pu", pad_pullup_o[17:16], 2'b10);
        rdchk("p2 pins", 8'ha2, 1'b0, 8'h02);
        ext_en[17] = 1'b1;
        step(3);
        rdchk("p2 pins low", 8'ha2, 1'b0, 8'h00);
        rdchk("p2 latch", 8'ha2, 1'b1, 8'h02);
        ext_en[17] = 1'b0;
        wr(8'he3, 8'hc0);
        step(1);
        check("pud", pad_pullup_o, 0);
        wr(8'he3, 8'h40);
        $display("t_cells done");
    endtask
    task automatic t_drive();
        wr(8'hf6, 8'hfd);
        step(1);
        check("hidrive", pad_hidrive_o, 18'h300ff);
        rdchk("drive rb", 8'hf6, 1'b0, 8'h05);
        wr(8'hf6, 8'h07);
        $display("t_drive done");
    endtask
    task automatic t_xbar();
        wr(8'he3, 8'h00);
        wr(8'ha0, 8'hfe);
        wr(8'ha8, 8'h11);
        step(1);
        check("xbar off", pad_oe_o[15:0], 0);
        wr(8'he3, 8'h40);
        step(1);
        check("xbar on", {pad_oe_o[0], pad_out_o[0]}, 2'b10);
        wr(8'he1, 8'h01);
        uart_tx_i = 1'b0;
        ext_en[5] = 1'b1;
        step(3);
        check("tx pin", {pad_oe_o[4], pad_out_o[4]}, 2'b10);
        check("rx", uart_rx_o, 0);
        periph_own_i[8] = 1'b1;
        step(2);
        check("periph od", pad_oe_o[8], 1);
        wr(8'had, 8'h01);
        wr(8'hac, 8'h30);
        step(3);
        check("skip pins", {pad_oe_o[8], pad_out_o[4], uart_rx_o}, 3'b011);
        check("skip copy", skip_o[15:0], 16'h0130);
        wr(8'hac, 8'h00);
        $display("t_xbar done");
    endtask
    task automatic t_match();
        ext_val[5] = 1'b1;
        wr(8'hfd, 8'h20);
        wr(8'hfe, 8'h20);
        step(3);
        check("match", mismatch_o, 0);
        ext_val[5] = 1'b0;
        idle_i = 1'b1;
        step(3);
        check("mismatch/wake", {mismatch_o, mismatch_wake_o}, 2'b11);
        idle_i = 1'b0;
        wr(8'hfe, 8'h00);
        wr(8'hee, 8'h01);
        wr(8'hed, 8'hfe);
        step(3);
        check("p1 mismatch/wake", {mismatch_o, mismatch_wake_o}, 2'b10);
        wr(8'hee, 8'h00);
        step(3);
        check("masked", mismatch_o, 0);
        $display("t_match done");
    endtask
    // Analog mode, then a write made while the clock enable is low must be lost
    task automatic t_analog();
        ext_val[16] = 1'b1;
        ext_en[16] = 1'b1;
        wr(8'ha6, 8'h02);
        step(1);
        check("analog", {pad_rx_en_o[17:16], pad_oe_o[16], pad_pullup_o[16]}, 4'b1000);
        step(2);
        rdchk("analog pins", 8'ha2, 1'b0, 8'h02);
        ce_i = 1'b0;
        wr(8'ha6, 8'h03);
        step(2);
        check("frozen rx_en", pad_rx_en_o[17:16], 2'b10);
        ce_i = 1'b1;
        rdchk("mode kept", 8'ha6, 1'b0, 8'h02);
        wr(8'ha6, 8'h03);
        ext_en[16] = 1'b0;
        step(1);
        check("digital again", pad_rx_en_o[17:16], 2'b11);
        $display("t_analog done");
    endtask

    // Hang guard
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end
    // Reset for 6 cycles, then the scenarios
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        t_reset();
        t_route();
        t_cells();
        t_drive();
        t_xbar();
        t_match();
        t_analog();
        end_of_test();
    end
endmodule
